// File: eee_lpi_ctrl.sv
// Purpose: Low power idle control at the MII of a 10/100 transceiver
// Assumes: mclk 10 MHz; MAC and line inputs are asynchronous pins
// Notes:   MII clocks are mclk/2, made here and driven to the MAC
`timescale 1ns/1ps
`default_nettype none
`include "eee_defs.svh"
module eee_lpi_ctrl #(
  parameter logic [4:0] PHY_ADDR    = 5'h01,
  parameter int         MCLK_MHZ    = `EEE_MCLK_MHZ,
  parameter int         PERIOD_CYC  = `EEE_PERIOD_US * `EEE_MCLK_MHZ,
  parameter int         REFRESH_CYC = `EEE_REFRESH_US * `EEE_MCLK_MHZ
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        mdc,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe_n,
  output logic             mii_txc,
  input  wire logic        mii_txen,
  input  wire logic        mii_txer,
  input  wire logic [3:0]  mii_txd,
  output logic             mii_rxc,
  output logic             mii_rxdv,
  output logic             mii_rxer,
  output logic [3:0]       mii_rxd,
  input  wire logic [3:0]  line_rxd,
  input  wire logic        line_rx_dv,
  input  wire logic        line_rx_er,
  input  wire logic        line_rx_pcode,
  input  wire logic        link_up,
  input  wire logic        link_100,
  input  wire logic        an_done,
  input  wire logic [15:0] an_lp_idle_adv,
  output logic [3:0]       line_txd,
  output logic             line_tx_en,
  output logic             line_tx_lpi,
  output logic             line_refresh,
  output logic             line_quiet,
  output logic             link_status,
  output logic             an_restart,
  output logic             adv_idle_100
);
  localparam int WAKE_CYC = `EEE_WAKE_US * MCLK_MHZ;
  localparam int WAKE_LAT = 4; // Two sync flops, state flop, output flop

  initial begin
    if (WAKE_LAT >= WAKE_CYC) $error("clock too slow for wake time");
    if (PHY_ADDR == 5'h00) $error("address zero is broadcast");
  end

  // Pin synchronisers; the first stage is read only by the second
  logic [31:0] pin_a_q, pin_s_q;
  logic        mii_tx_en_s, mii_tx_er_s, rx_dv_s, rx_er_s, pcode_s;
  logic        link_up_s, link_100_s, an_done_s, an_done_p_q;
  logic [3:0]  txd_s, rxd_s;
  logic [15:0] lp_adv_s;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_a_q <= 32'h0000_0000;
      pin_s_q <= 32'h0000_0000;
    end else begin
      pin_a_q <= {mii_txen, mii_txer, mii_txd, line_rxd, line_rx_dv,
                  line_rx_er, line_rx_pcode, link_up, link_100, an_done,
                  an_lp_idle_adv};
      pin_s_q <= pin_a_q;
    end
  end
  assign {mii_tx_en_s, mii_tx_er_s, txd_s, rxd_s, rx_dv_s, rx_er_s,
          pcode_s, link_up_s, link_100_s, an_done_s, lp_adv_s} = pin_s_q;

  // Management frames
  logic        wr_stb, rd_stb;
  logic [4:0]  reg_addr;
  logic [15:0] wr_data, rd_data;
  eee_mdio_slave #(
    .PHY_ADDR (PHY_ADDR)
  ) u_mdio (
    .mclk      (mclk),
    .rst       (rst),
    .mdc       (mdc),
    .mdio_i    (mdio_i),
    .mdio_o    (mdio_o),
    .mdio_oe_n (mdio_oe_n),
    .wr_stb    (wr_stb),
    .rd_stb    (rd_stb),
    .reg_addr  (reg_addr),
    .wr_data   (wr_data),
    .rd_data   (rd_data)
  );

  // Register state
  logic [15:0] bc_q, bc_d, acc_q, acc_d, mmd_ad_q, mmd_ad_d;
  logic        adv_q, adv_d, lp_q, lp_d, srst_q, srst_d, anr_q, anr_d;
  logic        mmd_hit_adv, mmd_hit_lp, acc_data, inc_rd, inc_wr;
  eee_pkg::eee_acc_fn_t acc_fn;

  assign acc_fn      = eee_pkg::eee_acc_fn_t'(acc_q[`EEE_ACC_FUNC_HI:`EEE_ACC_FUNC_LO]);
  assign acc_data    = (acc_fn != eee_pkg::ACC_ADDR);
  assign mmd_hit_adv = (acc_q[4:0] == `EEE_MMD_DEV_IDLE) && (mmd_ad_q == `EEE_MMD_ADV);
  assign mmd_hit_lp  = (acc_q[4:0] == `EEE_MMD_DEV_IDLE) && (mmd_ad_q == `EEE_MMD_LP_ADV);
  assign inc_rd      = (acc_fn == eee_pkg::ACC_INC_RW);
  assign inc_wr      = inc_rd || (acc_fn == eee_pkg::ACC_INC_WR);

  // Register writes, self-clearing bits and partner capture
  always_comb begin
    bc_d = bc_q; acc_d = acc_q; mmd_ad_d = mmd_ad_q;
    adv_d = adv_q; lp_d = lp_q; srst_d = 1'b0; anr_d = 1'b0;
    // Capture on negotiation done; a lost link forgets the partner
    if (!link_up_s) lp_d = 1'b0;
    else if (an_done_s && !an_done_p_q) lp_d = lp_adv_s[`EEE_ADV_100_BIT];
    if (wr_stb) begin
      unique case (reg_addr)
        `EEE_REG_BASIC_CTL: begin
          bc_d   = wr_data & `EEE_BC_RW_MASK;
          srst_d = wr_data[`EEE_BC_SRST];
          anr_d  = wr_data[`EEE_BC_RESTART_AN];
        end
        `EEE_REG_ACC_CTL:  acc_d = wr_data & `EEE_ACC_DEV_MASK;
        `EEE_REG_ACC_DATA: begin
          if (!acc_data) begin
            mmd_ad_d = wr_data;
          end else begin
            if (mmd_hit_adv) adv_d = wr_data[`EEE_ADV_100_BIT];
            if (inc_wr) mmd_ad_d = mmd_ad_q + 16'h0001;
          end
        end
        default: ;
      endcase
    end
    if (rd_stb && reg_addr == `EEE_REG_ACC_DATA && acc_data && inc_rd)
      mmd_ad_d = mmd_ad_q + 16'h0001;
    // Soft reset puts the idle function back to off
    if (srst_q) begin
      bc_d = `EEE_BC_RESET; acc_d = 16'h0000; mmd_ad_d = 16'h0000;
      adv_d = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bc_q <= `EEE_BC_RESET; acc_q <= 16'h0000; mmd_ad_q <= 16'h0000;
      adv_q <= 1'b0;
      lp_q <= 1'b0; srst_q <= 1'b0; anr_q <= 1'b0; an_done_p_q <= 1'b0;
    end else begin
      bc_q <= bc_d; acc_q <= acc_d; mmd_ad_q <= mmd_ad_d;
      adv_q <= adv_d; lp_q <= lp_d; srst_q <= srst_d; anr_q <= anr_d;
      an_done_p_q <= an_done_s;
    end
  end

  // Read mux; self-clearing bits always read zero
  always_comb begin
    rd_data = 16'h0000;
    unique case (reg_addr)
      `EEE_REG_BASIC_CTL: rd_data = bc_q;
      `EEE_REG_ACC_CTL:   rd_data = acc_q;
      `EEE_REG_ACC_DATA: begin
        if (!acc_data) rd_data = mmd_ad_q;
        else if (mmd_hit_adv) rd_data[`EEE_ADV_100_BIT] = adv_q;
        else if (mmd_hit_lp) rd_data[`EEE_ADV_100_BIT] = lp_q;
      end
      default: rd_data = 16'h0000;
    endcase
  end

  // Idle permitted only on a 100 Mbps link that both ends agreed on
  logic lpi_ok;
  assign lpi_ok = adv_q && lp_q && link_up_s && link_100_s && !bc_q[11];

  // Idle path state and MII clocks
  logic       div_q, div_d, tx_lpi_q, tx_lpi_d, rx_lpi_q, rx_lpi_d;
  logic       rx_stop_q, rx_stop_d, rxc_q, rxc_d;
  logic [3:0] rx_edges_q, rx_edges_d;
  always_comb begin
    div_d = ~div_q;
    // Entry needs the full request; staying needs enable and data only
    if (!tx_lpi_q)
      tx_lpi_d = lpi_ok && !mii_tx_en_s && mii_tx_er_s
                 && txd_s == `EEE_LPI_NIBBLE;
    else
      tx_lpi_d = lpi_ok && !mii_tx_en_s && txd_s == `EEE_LPI_NIBBLE;
    // Separate from the transmit path by construction
    rx_lpi_d = lpi_ok && pcode_s;
    rx_edges_d = rx_edges_q;
    rx_stop_d  = rx_stop_q;
    if (!rx_lpi_q) begin
      rx_edges_d = 4'h0;
      rx_stop_d  = 1'b0;
    end else if (!rx_stop_q) begin
      if (!div_q && rx_edges_q != 4'(`EEE_RXC_STOP_EDGES))
        rx_edges_d = rx_edges_q + 4'h1;
      // Stop only while the clock is about to go low: no runt pulse
      if (div_q && rx_edges_q == 4'(`EEE_RXC_STOP_EDGES))
        rx_stop_d = 1'b1;
    end
    rxc_d = rx_stop_d ? 1'b0 : div_d;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_q <= 1'b0; tx_lpi_q <= 1'b0; rx_lpi_q <= 1'b0;
      rx_stop_q <= 1'b0; rxc_q <= 1'b0; rx_edges_q <= 4'h0;
    end else begin
      div_q <= div_d; tx_lpi_q <= tx_lpi_d; rx_lpi_q <= rx_lpi_d;
      rx_stop_q <= rx_stop_d; rxc_q <= rxc_d; rx_edges_q <= rx_edges_d;
    end
  end
  assign mii_txc = div_q;
  assign mii_rxc = rxc_q;

  // Line side refresh and quiet sequencing
  logic refresh, quiet;
  eee_refresh_timer #(
    .REFRESH_CYC (REFRESH_CYC),
    .PERIOD_CYC  (PERIOD_CYC)
  ) u_refresh (
    .mclk    (mclk),
    .rst     (rst),
    .active  (tx_lpi_q),
    .refresh (refresh),
    .quiet   (quiet)
  );

  // Registered MII and line outputs, changed at the falling clock edge
  logic [3:0] rxd_q, rxd_d, ltxd_q, ltxd_d;
  logic       rxdv_q, rxdv_d, rxer_q, rxer_d, lten_q, lten_d;
  always_comb begin
    rxd_q_hold: begin
      rxd_d = rxd_q; rxdv_d = rxdv_q; rxer_d = rxer_q;
      ltxd_d = ltxd_q; lten_d = lten_q;
    end
    if (div_q) begin
      if (rx_lpi_q) begin
        rxdv_d = 1'b0; rxer_d = 1'b1; rxd_d = `EEE_LPI_NIBBLE;
      end else begin
        rxdv_d = rx_dv_s; rxer_d = rx_er_s; rxd_d = rxd_s;
      end
      // Frames pass straight through once tx_lpi_q drops; the error bit dropping alone does not end it
      ltxd_d = tx_lpi_q ? 4'h0 : txd_s;
      lten_d = tx_lpi_q ? 1'b0 : mii_tx_en_s;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rxd_q <= 4'h0; rxdv_q <= 1'b0; rxer_q <= 1'b0;
      ltxd_q <= 4'h0; lten_q <= 1'b0;
    end else begin
      rxd_q <= rxd_d; rxdv_q <= rxdv_d; rxer_q <= rxer_d;
      ltxd_q <= ltxd_d; lten_q <= lten_d;
    end
  end

  assign mii_rxd      = rxd_q;
  assign mii_rxdv     = rxdv_q;
  assign mii_rxer     = rxer_q;
  assign line_txd     = ltxd_q;
  assign line_tx_en   = lten_q;
  assign line_tx_lpi  = tx_lpi_q;
  assign line_refresh = refresh;
  assign line_quiet   = quiet;
  assign link_status  = link_up_s;
  assign an_restart   = anr_q;
  assign adv_idle_100 = adv_q;
endmodule
`default_nettype wire

// File: eee_defs.svh
// Purpose: Offsets, field positions, reset values and timing figures
// Assumes: Included by every design file of the idle block but the package
// Notes:   Times are in microseconds; cycle counts are derived in code
`ifndef EEE_DEFS_SVH
`define EEE_DEFS_SVH
// Standard register addresses
`define EEE_REG_BASIC_CTL  5'h00
`define EEE_REG_ACC_CTL    5'h0d
`define EEE_REG_ACC_DATA   5'h0e
// Indirect device and register addresses
`define EEE_MMD_DEV_IDLE   5'h07
`define EEE_MMD_ADV        16'h003c
`define EEE_MMD_LP_ADV     16'h003d
// Basic control fields
`define EEE_BC_SRST        15
`define EEE_BC_RESTART_AN  9
`define EEE_BC_RW_MASK     16'h7d80
`define EEE_BC_RESET       16'h3100
// Indirect access control fields
`define EEE_ACC_FUNC_HI    15
`define EEE_ACC_FUNC_LO    14
`define EEE_ACC_DEV_MASK   16'hc01f
// Advertisement bit for 100 Mbps idle
`define EEE_ADV_100_BIT    1
// Timing figures
`define EEE_MCLK_MHZ       10
`define EEE_REFRESH_US     200
`define EEE_PERIOD_US      20000
`define EEE_WAKE_US        30
`define EEE_RXC_STOP_EDGES 9
`define EEE_PREAMBLE_BITS  32
// Transmit idle request nibble
`define EEE_LPI_NIBBLE     4'h1
`endif

// File: eee_pkg.sv
// Purpose: Shared types of the low power idle block
// Assumes: Constants live in eee_defs.svh
// Notes:   One-hot codes are written out for the serial slave
package eee_pkg;
  typedef enum logic [4:0] {
    MS_IDLE = 5'h01,
    MS_HDR  = 5'h02,
    MS_TA   = 5'h04,
    MS_RDAT = 5'h08,
    MS_WDAT = 5'h10
  } eee_mdio_st_t;
  typedef enum logic [1:0] {
    ACC_ADDR    = 2'h0,
    ACC_DATA    = 2'h1,
    ACC_INC_RW  = 2'h2,
    ACC_INC_WR  = 2'h3
  } eee_acc_fn_t;
endpackage

// File: eee_mdio_slave.sv
// Purpose: Serial management slave, one register access per frame
// Assumes: mdc slower than mclk/4; both pins synchronised here
// Notes:   Output changes after the mclk that sees an mdc rise
`timescale 1ns/1ps
`default_nettype none
`include "eee_defs.svh"
module eee_mdio_slave #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        mdc,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe_n,
  output logic             wr_stb,
  output logic             rd_stb,
  output logic [4:0]       reg_addr,
  output logic [15:0]      wr_data,
  input  wire logic [15:0] rd_data
);
  logic [2:0] mdc_s_q;
  logic [1:0] dio_s_q;
  eee_pkg::eee_mdio_st_t st_q, st_d;
  logic [5:0] ones_q, ones_d;
  logic [3:0] cnt_q, cnt_d;
  logic [15:0] sh_q, sh_d, wd_q, wd_d;
  logic rd_q, rd_d, o_q, o_d, oen_q, oen_d, ws_q, ws_d, rs_q, rs_d;
  logic [4:0] ad_q, ad_d;
  logic rise, bit_in;
  logic [13:0] hdr;

  // Two flops per pin; third mdc flop only feeds the edge detector
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mdc_s_q <= 3'h7; // Idle-high clock: no false rise after reset
      dio_s_q <= 2'h3;
    end else begin
      mdc_s_q <= {mdc_s_q[1:0], mdc};
      dio_s_q <= {dio_s_q[0], mdio_i};
    end
  end
  assign rise   = mdc_s_q[1] & ~mdc_s_q[2];
  assign bit_in = dio_s_q[1];
  assign hdr    = {sh_q[12:0], bit_in};

  // Frame decoder: preamble, header, turnaround, data
  always_comb begin
    st_d = st_q; ones_d = ones_q; cnt_d = cnt_q; sh_d = sh_q;
    wd_d = wd_q; rd_d = rd_q; o_d = o_q; oen_d = oen_q;
    ad_d = ad_q; ws_d = 1'b0; rs_d = 1'b0;
    if (rise) begin
      unique case (st_q)
        eee_pkg::MS_IDLE: begin
          if (bit_in) begin
            ones_d = ones_q[5] ? ones_q : ones_q + 6'h01;
          end else if (ones_q >= 6'(`EEE_PREAMBLE_BITS)) begin
            st_d = eee_pkg::MS_HDR; cnt_d = 4'h1; sh_d = 16'h0000;
          end else begin
            ones_d = 6'h00;
          end
        end
        eee_pkg::MS_HDR: begin
          sh_d = {sh_q[14:0], bit_in}; cnt_d = cnt_q + 4'h1;
          if (cnt_q == 4'hd) begin
            ones_d = 6'h00; cnt_d = 4'h0; ad_d = hdr[4:0];
            // Wrong start, opcode or address: sit out until preamble
            if (hdr[13:12] == 2'h1 && hdr[9:5] == PHY_ADDR &&
                (hdr[11:10] == 2'h2 || hdr[11:10] == 2'h1)) begin
              st_d = eee_pkg::MS_TA; rd_d = hdr[11];
            end else begin
              st_d = eee_pkg::MS_IDLE;
            end
          end
        end
        eee_pkg::MS_TA: begin
          cnt_d = cnt_q + 4'h1;
          if (rd_q && cnt_q == 4'h0) begin
            rs_d = 1'b1; o_d = 1'b0; oen_d = 1'b0;
          end else if (cnt_q != 4'h0) begin
            cnt_d = 4'h0;
            if (rd_q) begin
              st_d = eee_pkg::MS_RDAT;
              o_d = wd_q[15]; wd_d = {wd_q[14:0], 1'b0};
            end else begin
              st_d = eee_pkg::MS_WDAT;
            end
          end
        end
        eee_pkg::MS_RDAT: begin
          cnt_d = cnt_q + 4'h1;
          o_d = wd_q[15]; wd_d = {wd_q[14:0], 1'b0};
          if (cnt_q == 4'hf) begin
            oen_d = 1'b1; o_d = 1'b1; st_d = eee_pkg::MS_IDLE;
          end
        end
        eee_pkg::MS_WDAT: begin
          sh_d = {sh_q[14:0], bit_in}; cnt_d = cnt_q + 4'h1;
          if (cnt_q == 4'hf) begin
            wd_d = {sh_q[14:0], bit_in}; ws_d = 1'b1;
            st_d = eee_pkg::MS_IDLE;
          end
        end
        default: st_d = eee_pkg::MS_IDLE;
      endcase
    end
    // Read data taken one mclk after the strobe, once the mux settles
    if (rs_q) wd_d = rd_data;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= eee_pkg::MS_IDLE; ones_q <= 6'h00; cnt_q <= 4'h0;
      sh_q <= 16'h0000; wd_q <= 16'h0000; rd_q <= 1'b0;
      o_q <= 1'b1; oen_q <= 1'b1; ad_q <= 5'h00;
      ws_q <= 1'b0; rs_q <= 1'b0;
    end else begin
      st_q <= st_d; ones_q <= ones_d; cnt_q <= cnt_d;
      sh_q <= sh_d; wd_q <= wd_d; rd_q <= rd_d;
      o_q <= o_d; oen_q <= oen_d; ad_q <= ad_d;
      ws_q <= ws_d; rs_q <= rs_d;
    end
  end
  assign mdio_o    = o_q;
  assign mdio_oe_n = oen_q;
  assign wr_stb    = ws_q;
  assign rd_stb    = rs_q;
  assign reg_addr  = ad_q;
  assign wr_data   = wd_q;
endmodule
`default_nettype wire

// File: eee_refresh_timer.sv
// Purpose: Refresh burst and quiet period sequencer for transmit idle
// Assumes: active is a clean level from the idle state machine
// Notes:   Burst comes first so the partner sees a refresh on entry
`timescale 1ns/1ps
`default_nettype none
`include "eee_defs.svh"
module eee_refresh_timer #(
  parameter int REFRESH_CYC = 2000,
  parameter int PERIOD_CYC  = 200000
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic active,
  output logic      refresh,
  output logic      quiet
);
  localparam int CW = $clog2(PERIOD_CYC);
  logic [CW-1:0] cnt_q, cnt_d;
  logic ref_q, ref_d, qt_q, qt_d;

  initial begin
    if (REFRESH_CYC < 1 || REFRESH_CYC >= PERIOD_CYC)
      $error("refresh burst must be shorter than its period");
  end

  // Free count while active; dropped the moment traffic returns
  always_comb begin
    cnt_d = cnt_q; ref_d = 1'b0; qt_d = 1'b0;
    if (active) begin
      cnt_d = (cnt_q == CW'(PERIOD_CYC - 1)) ? '0 : cnt_q + 1'b1;
      ref_d = (cnt_q < CW'(REFRESH_CYC));
      qt_d  = ~ref_d;
    end else begin
      cnt_d = '0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0; ref_q <= 1'b0; qt_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d; ref_q <= ref_d; qt_q <= qt_d;
    end
  end
  assign refresh = ref_q;
  assign quiet   = qt_q;
endmodule
`default_nettype wire

// File: eee_lpi_ctrl_asserts.sv
// Purpose: Concurrent checks on the idle block's MII and line side
// Assumes: Bound into eee_lpi_ctrl; one mclk domain
// Notes:   Long run lengths are counted in helper registers
`timescale 1ns/1ps
`default_nettype none
module eee_lpi_ctrl_asserts #(
  parameter int PERIOD_CYC  = 200000,
  parameter int REFRESH_CYC = 2000
) (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       mii_txc,
  input wire logic       mii_txen,
  input wire logic       mii_txer,
  input wire logic [3:0] mii_txd,
  input wire logic       mii_rxc,
  input wire logic       mii_rxdv,
  input wire logic       mii_rxer,
  input wire logic [3:0] mii_rxd,
  input wire logic       line_tx_lpi,
  input wire logic       line_refresh,
  input wire logic       line_quiet,
  input wire logic       link_status,
  input wire logic       an_restart,
  input wire logic       adv_idle_100
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic [31:0] ref_q, ref_d, qt_q, qt_d;
  logic [5:0]  idl_q, idl_d;
  logic        req_pat, rx_idle;
  // Run lengths; idle count saturates so it never wraps
  always_comb begin
    req_pat = !mii_txen && mii_txer && (mii_txd == 4'h1);
    rx_idle = !mii_rxdv && mii_rxer && (mii_rxd == 4'h1);
    ref_d   = line_refresh ? ref_q + 32'h1 : 32'h0;
    qt_d    = line_quiet ? qt_q + 32'h1 : 32'h0;
    idl_d   = !rx_idle ? 6'h00 : idl_q + {5'h00, idl_q != 6'h3f};
  end
  // Registers only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ref_q <= 32'h0;
      qt_q  <= 32'h0;
      idl_q <= 6'h00;
    end else begin
      ref_q <= ref_d;
      qt_q  <= qt_d;
      idl_q <= idl_d;
    end
  end
  // Stopped clock: low twice running, reset edges excluded
  sequence rxc_halted;
    !mii_rxc ##1 !mii_rxc;
  endsequence
  sequence first_halt;
    !mii_rxc && !$past(mii_rxc) && rx_idle && !$past(rst) && !$past(rst, 2);
  endsequence
  txc_runs_a: assert property (1'b1 |=> mii_txc != $past(mii_txc))
    else $error("transmit clock stalled");
  tx_entry_a: assert property ($rose(line_tx_lpi) |-> $past(req_pat, 2))
    else $error("transmit idle without request");
  tx_exit_a: assert property (line_tx_lpi && mii_txen |-> ##[1:4] !line_tx_lpi)
    else $error("transmit idle kept after enable");
  tx_allowed_a: assert property (line_tx_lpi |-> adv_idle_100 && link_status)
    else $error("transmit idle while not allowed");
  refresh_len_a: assert property ($fell(line_refresh) && line_tx_lpi |-> ref_q == REFRESH_CYC)
    else $error("refresh burst length wrong");
  quiet_len_a: assert property ($fell(line_quiet) && line_tx_lpi |->
    qt_q == PERIOD_CYC - REFRESH_CYC) else $error("quiet period length wrong");
  idle_off_a: assert property (!line_tx_lpi && !$past(line_tx_lpi) |->
    !line_refresh && !line_quiet) else $error("refresh or quiet outside idle");
  rxc_late_a: assert property (first_halt |-> idl_q >= 6'h10)
    else $error("receive clock stopped too early");
  rxc_stops_a: assert property (idl_q == 6'h28 |-> rxc_halted)
    else $error("receive clock still running in idle");
  restart_pulse_a: assert property (an_restart |=> !an_restart)
    else $error("restart pulse too long");
endmodule
bind eee_lpi_ctrl eee_lpi_ctrl_asserts #(.PERIOD_CYC(PERIOD_CYC), .REFRESH_CYC(REFRESH_CYC))
  chk (.*);
`default_nettype wire

// File: eee_mac_model.sv
// Purpose: MAC side model driving the transmit MII pins
// Assumes: One nibble per mii_txc period, moved just after mclk rises
// Notes:   Idle data walks a pattern so no stale nibble lingers
`timescale 1ns/1ps
`default_nettype none
module eee_mac_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       mii_txc,
  input  wire logic       lpi_req,
  input  wire logic       send,
  input  wire logic [3:0] nib,
  output logic            mii_txen,
  output logic            mii_txer,
  output logic [3:0]      mii_txd
);
  // Request pattern wins over data; otherwise send or idle walk
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      {mii_txen, mii_txer, mii_txd} <= 6'h00;
    end else if (mii_txc) begin
      mii_txen <= send && !lpi_req;
      mii_txer <= lpi_req;
      mii_txd  <= lpi_req ? 4'h1 : send ? nib : mii_txd + 4'h5;
    end
  end
endmodule
`default_nettype wire

// File: tb.sv
// Purpose: Self-checking bench for the low power idle block
// Assumes: Short refresh counts; management clock bit-banged at 800 ns
// Notes:   Driver queues expected values; a watcher compares them
`timescale 1ns/1ps
`default_nettype none
`include "eee_defs.svh"
module tb;
  logic        mclk, rst, mdc, host_b, mdio_i, mdio_o, mdio_oe_n, lpi_req, send, r;
  logic        mii_txc, mii_txen, mii_txer, mii_rxc, mii_rxdv, mii_rxer;
  logic        line_rx_dv, line_rx_er, line_rx_pcode, link_up, link_100, an_done;
  logic        line_tx_en, line_tx_lpi, line_refresh, line_quiet, link_status;
  logic        an_restart, adv_idle_100, anr_seen;
  logic [3:0]  nib, mii_txd, mii_rxd, line_rxd, line_txd;
  logic [15:0] an_lp_idle_adv, obs, e, rxw;
  logic [15:0] exp_q[$];
  int          bad_count, total_checks, cyc_n, seed;
  event        got_e;
  // Released data line pulls up; device drives when enable is low
  assign mdio_i = host_b & (mdio_oe_n | mdio_o);
  assign rxw    = {10'h000, mii_rxdv, mii_rxer, mii_rxd};
  eee_lpi_ctrl #(.PERIOD_CYC(200), .REFRESH_CYC(20)) uut (.*);
  eee_mac_model mac (.*);
  // Clock and hang limit
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc_n++;
    if (an_restart) anr_seen = 1'b1;
    if (cyc_n == 20000) begin
      bad_count++;
      summarize();
    end
  end
  // Oldest note against each observed value
  always @(got_e) begin
    e = exp_q.pop_front();
    total_checks++;
    if (obs !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, obs, e);
    end
  end
  task automatic look(input logic [15:0] ev, input logic [15:0] gv);
    exp_q.push_back(ev);
    obs = gv;
    ->got_e;
    #1;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // One management bit: set while low, sample just before the rise
  task automatic mbit(input logic b, output logic s);
    mdc = 1'b0;
    host_b = b;
    cyc(4);
    s = mdio_i;
    mdc = 1'b1;
    cyc(4);
  endtask
  task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rv);
    logic [13:0] hd;
    logic        s;
    hd = {2'b01, op, 5'h01, ra};
    for (int i = 0; i < 32; i++) mbit(1'b1, s);
    for (int i = 13; i >= 0; i--) mbit(hd[i], s);
    mbit(1'b1, s);
    mbit(op[1], s);
    for (int i = 15; i >= 0; i--) mbit(op[1] | wd[i], rv[i]);
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] v;
    frame(2'b01, ra, d, v);
  endtask
  task automatic rd(input logic [4:0] ra, input logic [15:0] ev);
    logic [15:0] v;
    frame(2'b10, ra, 16'h0000, v);
    look(ev, v);
  endtask
  task automatic sel(input logic [15:0] a);
    wr(`EEE_REG_ACC_CTL, 16'h0007);
    wr(`EEE_REG_ACC_DATA, a);
    wr(`EEE_REG_ACC_CTL, 16'h4007);
  endtask
  task automatic rxc_on(input logic [15:0] ev);
    r = 1'b0;
    repeat (4) begin
      @(negedge mclk);
      r = r | mii_rxc;
    end
    look(ev, {15'h0000, r});
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    mclk = 1'b0;
    seed = 92596;
    anr_seen = 1'b0;
    {rst, mdc, host_b, link_up, link_100} = 5'h1f;
    {lpi_req, send, line_rx_dv, line_rx_er, line_rx_pcode, an_done} = 6'h00;
    {nib, line_rxd, an_lp_idle_adv} = 24'h000000;
    cyc(20);
    rst = 1'b0;
    cyc(5);
    rd(`EEE_REG_BASIC_CTL, `EEE_BC_RESET);
    rd(5'h05, 16'h0000);
    sel(`EEE_MMD_ADV);
    rd(`EEE_REG_ACC_DATA, 16'h0000);
    lpi_req = 1'b1;
    cyc(20);
    look(16'h0000, {15'h0000, line_tx_lpi});
    lpi_req = 1'b0;
    $display("test reset done");
    // Advertise, restart negotiation, capture partner advert
    wr(`EEE_REG_ACC_DATA, 16'h0002);
    rd(`EEE_REG_ACC_DATA, 16'h0002);
    look(16'h0001, {15'h0000, adv_idle_100});
    wr(`EEE_REG_BASIC_CTL, 16'h3300);
    cyc(4);
    look(16'h0001, {15'h0000, anr_seen});
    rd(`EEE_REG_BASIC_CTL, `EEE_BC_RESET);
    an_lp_idle_adv = 16'($random(seed)) | 16'h0002;
    an_done = 1'b1;
    sel(`EEE_MMD_LP_ADV);
    wr(`EEE_REG_ACC_DATA, 16'h0000);
    rd(`EEE_REG_ACC_DATA, 16'h0002);
    $display("test enable done");
    // Both paths idle through more than a full refresh period
    lpi_req = 1'b1;
    line_rx_pcode = 1'b1;
    cyc(40);
    look(16'h0001, {15'h0000, line_tx_lpi});
    look(16'h0011, rxw);
    rxc_on(16'h0000);
    cyc(400);
    look(16'h0003, {14'h0000, line_tx_lpi, link_status});
    look(16'h0011, rxw);
    // Traffic ends transmit idle while receive idle stays
    nib = 4'h8 | 4'($random(seed));
    send = 1'b1;
    lpi_req = 1'b0;
    cyc(8);
    look({12'h001, nib}, {11'h000, line_tx_en, line_txd});
    look(16'h0011, rxw);
    line_rxd = 4'($random(seed));
    {line_rx_dv, line_rx_pcode} = 2'h2;
    cyc(8);
    look({12'h002, line_rxd}, rxw);
    rxc_on(16'h0001);
    // Enable stays low; the error bit and the data nibble move away
    send = 1'b0;
    lpi_req = 1'b1;
    cyc(10);
    lpi_req = 1'b0;
    cyc(8);
    look(16'h0000, {15'h0000, line_tx_lpi});
    $display("test idle done");
    // Refused at 10 Mbps; soft reset turns idle off
    link_100 = 1'b0;
    lpi_req = 1'b1;
    cyc(10);
    look(16'h0000, {15'h0000, line_tx_lpi});
    lpi_req = 1'b0;
    cyc(6);
    link_100 = 1'b1;
    wr(`EEE_REG_BASIC_CTL, 16'h8000);
    cyc(4);
    look(16'h0000, {15'h0000, adv_idle_100});
    rd(`EEE_REG_BASIC_CTL, `EEE_BC_RESET);
    $display("test refuse done");
    summarize();
  end
endmodule
`default_nettype wire
